// ===== core/wdcfg_pkg.sv
// Package with register map, field layout and timing constants of the watchdog block
package wdcfg_pkg;

	localparam int unsigned WDCFG_ADDR_W       = 12;
	localparam int unsigned WDCFG_DATA_W       = 32;

	localparam logic [11:0] WDCFG_OFF_CTRL     = 12'h000;
	localparam logic [11:0] WDCFG_OFF_CAUSE    = 12'h004;
	localparam logic [11:0] WDCFG_OFF_IRQ_STAT = 12'h008;
	localparam logic [11:0] WDCFG_OFF_IRQ_MASK = 12'h00c;

	localparam int unsigned WDCFG_CTRL_CHG_BIT = 4;
	localparam int unsigned WDCFG_CTRL_EN_BIT  = 3;
	localparam int unsigned WDCFG_CTRL_SEL_LSB = 0;
	localparam int unsigned WDCFG_SEL_W        = 3;
	localparam logic [7:0]  WDCFG_CTRL_RESET   = 8'h00;

	localparam int unsigned WDCFG_CAUSE_WD     = 3;
	localparam int unsigned WDCFG_CAUSE_BO     = 2;
	localparam int unsigned WDCFG_CAUSE_PIN    = 1;
	localparam int unsigned WDCFG_CAUSE_POR    = 0;
	localparam int unsigned WDCFG_CAUSE_W      = 4;
	localparam logic [3:0]  WDCFG_CAUSE_RESET  = 4'h1;

	localparam int unsigned WDCFG_IRQ_TIMEOUT  = 0;
	localparam int unsigned WDCFG_IRQ_REJECT   = 1;
	localparam int unsigned WDCFG_IRQ_W        = 2;
	localparam logic [1:0]  WDCFG_IRQ_RESET    = 2'h0;

	// Change window, in system clock cycles
	localparam logic [2:0]  WDCFG_WIN_CYC      = 3'h4;

	// Watchdog oscillator and timeout base (oscillator cycles)
	localparam int unsigned WDCFG_PCLK_KHZ     = 250000;
	localparam int unsigned WDCFG_OSC_KHZ      = 1000;
	localparam int unsigned WDCFG_BASE_CYC     = 16384;
	localparam int unsigned WDCFG_CNT_W        = 22;

	localparam int unsigned WDCFG_SYNC_N       = 3;
	localparam int unsigned WDCFG_PIN_OSC      = 0;
	localparam int unsigned WDCFG_PIN_RSTN     = 1;
	localparam int unsigned WDCFG_PIN_BO       = 2;
	localparam int unsigned WDCFG_PIN_FUSE     = 3;
	localparam int unsigned WDCFG_PIN_N        = 4;
	localparam logic [3:0]  WDCFG_PIN_IDLE     = 4'h2;

	typedef struct packed {
		logic                   chg_en;
		logic                   en;
		logic [WDCFG_SEL_W-1:0] sel;
	} wdcfg_ctrl_t;

endpackage

// ===== core/wdcfg_cnt.sv
// Watchdog timeout counter stepped by oscillator ticks
`timescale 1ns/1ns
`default_nettype none
module wdcfg_cnt
	import wdcfg_pkg::*;
#(
	parameter int unsigned BASE_CYC = WDCFG_BASE_CYC
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   tick,
	input  wire logic                   restart,
	input  wire logic                   run,
	input  wire logic [WDCFG_SEL_W-1:0] sel,
	output logic                        expire
);

	logic [WDCFG_CNT_W-1:0] count_reg;
	logic [WDCFG_CNT_W-1:0] limit;
	logic                   hit;

	// Each code doubles the base count
	assign limit = WDCFG_CNT_W'(BASE_CYC) << sel;
	// At or past the limit, so a shortened timeout still expires
	assign hit   = run && tick && (count_reg >= limit - 1'b1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else if (restart || hit) begin
			count_reg <= '0;
		end else if (run && tick) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			expire <= 1'b0;
		end else begin
			expire <= hit && !restart;
		end
	end

endmodule
`default_nettype wire

// ===== core/wdcfg_top.sv
// Watchdog with timed configuration changes and reset-cause flags, APB slave
// Notes on behaviour
// - Lower level: starts off, enable write sets it
// - Open write then config write within four clocks
// - Higher level: always runs, enable reads one
// - Higher level: window write updates timeout only
// - Change-enable self-clears four clocks after set
// - Enable clears only while change-enable is one, or on a chip reset
// - Timeout code selects 16384 doubling to 2097152
// - Watchdog reset sets bit 3, software clears
// - Brown-out sets bit 2, software clears
// - Pin reset sets bit 1, software clears
// - Power-on sets bit 0, only software clears
// - Upper four cause bits read zero
// - Upper three control bits read zero
// - Counter steps on separate 1 MHz oscillator
// - Kick, disable or chip reset restarts count
// - Expiry gives one-clock reset pulse
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module wdcfg_top
	import wdcfg_pkg::*;
#(
	parameter int unsigned TIMEOUT_BASE_CYC = WDCFG_BASE_CYC
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic [WDCFG_ADDR_W-1:0] paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [WDCFG_DATA_W-1:0] pwdata,
	output logic                         pready,
	output logic      [WDCFG_DATA_W-1:0] prdata,
	output logic                         pslverr,
	input  wire logic                    wd_osc,
	input  wire logic                    pin_reset_n,
	input  wire logic                    brownout_det,
	input  wire logic                    always_on_fuse,
	input  wire logic                    watchdog_kick,
	output logic                         wd_reset,
	output logic                         wd_running,
	output logic                         irq
);

	// Pin synchronisers
	logic [WDCFG_PIN_N-1:0] sync1_reg;
	logic [WDCFG_PIN_N-1:0] sync2_reg;
	logic [WDCFG_PIN_N-1:0] sync3_reg;
	logic [WDCFG_PIN_N-1:0] pin_reg;
	logic [WDCFG_PIN_N-1:0] pin_prev_reg;
	logic [WDCFG_PIN_N-1:0] pin_raw;

	assign pin_raw[WDCFG_PIN_OSC]  = wd_osc;
	assign pin_raw[WDCFG_PIN_RSTN] = pin_reset_n;
	assign pin_raw[WDCFG_PIN_BO]   = brownout_det;
	assign pin_raw[WDCFG_PIN_FUSE] = always_on_fuse;

	genvar gi;
	generate
		for (gi = 0; gi < WDCFG_PIN_N; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					// Idle levels, so no false edge follows reset
					sync1_reg[gi]    <= WDCFG_PIN_IDLE[gi];
					sync2_reg[gi]    <= WDCFG_PIN_IDLE[gi];
					sync3_reg[gi]    <= WDCFG_PIN_IDLE[gi];
					pin_reg[gi]      <= WDCFG_PIN_IDLE[gi];
					pin_prev_reg[gi] <= WDCFG_PIN_IDLE[gi];
				end else begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					sync3_reg[gi] <= sync2_reg[gi];
					// A change only counts once two stages agree
					if (sync2_reg[gi] == sync3_reg[gi]) begin
						pin_reg[gi] <= sync3_reg[gi];
					end
					pin_prev_reg[gi] <= pin_reg[gi];
				end
			end
		end
	endgenerate

	logic osc_tick;
	logic pin_rst_evt;
	logic bo_evt;
	logic level2;
	logic chip_rst;

	// Edges come from the filtered copies, so a glitch gives no tick
	assign osc_tick    = pin_reg[WDCFG_PIN_OSC] && !pin_prev_reg[WDCFG_PIN_OSC];
	assign pin_rst_evt = !pin_reg[WDCFG_PIN_RSTN] && pin_prev_reg[WDCFG_PIN_RSTN];
	assign bo_evt      = pin_reg[WDCFG_PIN_BO] && !pin_prev_reg[WDCFG_PIN_BO];
	// Fuse is a strap, followed all the time, not latched at reset
	assign level2      = pin_reg[WDCFG_PIN_FUSE];

	// APB decode, zero wait states
	logic                    acc;
	logic                    wr;
	logic                    rd;
	logic                    hit_ctrl;
	logic                    hit_cause;
	logic                    hit_stat;
	logic                    hit_mask;
	logic                    mapped;
	wdcfg_ctrl_t             wdata_ctrl;

	assign acc        = psel && penable;
	assign wr         = acc && pwrite;
	assign rd         = psel && !penable && !pwrite;
	assign hit_ctrl   = (paddr == WDCFG_OFF_CTRL);
	assign hit_cause  = (paddr == WDCFG_OFF_CAUSE);
	assign hit_stat   = (paddr == WDCFG_OFF_IRQ_STAT);
	assign hit_mask   = (paddr == WDCFG_OFF_IRQ_MASK);
	assign mapped     = hit_ctrl || hit_cause || hit_stat || hit_mask;
	assign pready     = 1'b1;
	assign wdata_ctrl = wdcfg_ctrl_t'(pwdata[WDCFG_CTRL_CHG_BIT:0]);

	// Control register and change window
	wdcfg_ctrl_t ctrl_reg;
	logic [2:0]  win_reg;
	logic        en_eff;
	logic        ctrl_wr;
	logic        open_wr;
	logic        in_win;
	logic        rejected;
	logic        expire;

	assign ctrl_wr = wr && hit_ctrl;
	assign open_wr = ctrl_wr && wdata_ctrl.chg_en && wdata_ctrl.en;
	assign in_win  = ctrl_reg.chg_en;
	assign en_eff  = level2 || ctrl_reg.en;

	// A non-opening write outside the window that tries a disable or timeout change
	assign rejected = ctrl_wr && !open_wr && !in_win &&
		((!wdata_ctrl.en && en_eff) || (wdata_ctrl.sel != ctrl_reg.sel));

	// Chip reset events; the control register and window counter return to reset and the timeout count restarts
	assign chip_rst = expire || pin_rst_evt || bo_evt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= wdcfg_ctrl_t'(WDCFG_CTRL_RESET[WDCFG_CTRL_CHG_BIT:0]);
		end else if (chip_rst) begin
			// Any chip reset returns the control register to its initial configuration
			ctrl_reg <= wdcfg_ctrl_t'(WDCFG_CTRL_RESET[WDCFG_CTRL_CHG_BIT:0]);
		end else begin
			if (ctrl_wr) begin
				if (open_wr) begin
					ctrl_reg.chg_en <= 1'b1;
					ctrl_reg.en     <= 1'b1;
				end else if (in_win) begin
					// Window writes leave the window open until it times out
					if (!level2) begin
						ctrl_reg.en <= wdata_ctrl.en;
					end
					ctrl_reg.sel <= wdata_ctrl.sel;
				end else if (!level2 && wdata_ctrl.en) begin
					ctrl_reg.en <= 1'b1;
				end
			end
			if (!open_wr && win_reg == 3'h1) begin
				ctrl_reg.chg_en <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_reg <= 3'h0;
		end else if (chip_rst) begin
			win_reg <= 3'h0;
		end else if (open_wr) begin
			// A reopen restarts the full four clocks
			win_reg <= WDCFG_WIN_CYC;
		end else if (win_reg != 3'h0) begin
			win_reg <= win_reg - 3'h1;
		end
	end

	// Timeout counter
	wdcfg_cnt #(
		.BASE_CYC (TIMEOUT_BASE_CYC)
	) u_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (osc_tick),
		.restart (watchdog_kick || !en_eff || chip_rst),
		.run     (en_eff),
		.sel     (ctrl_reg.sel),
		.expire  (expire)
	);

	assign wd_reset   = expire;

	// Registered status pin, one clock behind the enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_running <= 1'b0;
		end else begin
			wd_running <= en_eff;
		end
	end

	// Reset-cause flags, a new cause wins over a clearing write
	logic [WDCFG_CAUSE_W-1:0] cause_reg;
	logic [WDCFG_CAUSE_W-1:0] cause_set;
	logic                     cause_wr;

	assign cause_set[WDCFG_CAUSE_WD]  = expire;
	assign cause_set[WDCFG_CAUSE_BO]  = bo_evt;
	assign cause_set[WDCFG_CAUSE_PIN] = pin_rst_evt;
	assign cause_set[WDCFG_CAUSE_POR] = 1'b0;
	assign cause_wr = wr && hit_cause;

	generate
		for (gi = 0; gi < WDCFG_CAUSE_W; gi++) begin : g_cause
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					// Power-on sets its own flag and clears the others
					cause_reg[gi] <= WDCFG_CAUSE_RESET[gi];
				end else if (cause_set[gi]) begin
					cause_reg[gi] <= 1'b1;
				end else if (cause_wr && !pwdata[gi]) begin
					cause_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Interrupt status and mask
	logic [WDCFG_IRQ_W-1:0] irq_stat_reg;
	logic [WDCFG_IRQ_W-1:0] irq_mask_reg;
	logic [WDCFG_IRQ_W-1:0] irq_set;

	assign irq_set[WDCFG_IRQ_TIMEOUT] = expire;
	assign irq_set[WDCFG_IRQ_REJECT]  = rejected;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= WDCFG_IRQ_RESET;
		end else begin
			// Set wins over a write-one clear in the same clock
			irq_stat_reg <= irq_set |
				(irq_stat_reg & ~((wr && hit_stat) ? pwdata[WDCFG_IRQ_W-1:0] : '0));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= WDCFG_IRQ_RESET;
		end else if (wr && hit_mask) begin
			irq_mask_reg <= pwdata[WDCFG_IRQ_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			// One clock behind the status, but glitch free
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Read mux; unused bits read as zero
	logic [WDCFG_DATA_W-1:0] rdata;

	always_comb begin
		rdata = '0;
		if (hit_ctrl) begin
			rdata[WDCFG_CTRL_CHG_BIT]                        = ctrl_reg.chg_en;
			rdata[WDCFG_CTRL_EN_BIT]                         = en_eff;
			rdata[WDCFG_CTRL_SEL_LSB +: WDCFG_SEL_W]         = ctrl_reg.sel;
		end else if (hit_cause) begin
			rdata[WDCFG_CAUSE_W-1:0] = cause_reg;
		end else if (hit_stat) begin
			rdata[WDCFG_IRQ_W-1:0] = irq_stat_reg;
		end else if (hit_mask) begin
			rdata[WDCFG_IRQ_W-1:0] = irq_mask_reg;
		end
	end

	// Captured in setup: no wait state, but the value is one clock old
	logic [WDCFG_DATA_W-1:0] prdata_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
		end else begin
			prdata_reg <= rd ? rdata : '0;
		end
	end

	assign prdata  = prdata_reg;
	assign pslverr = acc && !mapped;

endmodule
`default_nettype wire

// ===== tb/wdcfg_monitor.sv
// Port-level timing checks for the watchdog block
`timescale 1ns/1ns
`default_nettype none
module wdcfg_monitor
	import wdcfg_pkg::*;
#(
	parameter int unsigned TIMEOUT_BASE_CYC = WDCFG_BASE_CYC
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        always_on_fuse,
	input wire logic        watchdog_kick,
	input wire logic        wd_reset,
	input wire logic        wd_running
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire rd_acc = psel & penable & ~pwrite;

	pready_const_a: assert property (pready) else $error("pready low");
	err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
	err_unmapped_a: assert property (psel && penable && paddr > WDCFG_OFF_IRQ_MASK |-> pslverr)
		else $error("unmapped not refused");
	rdata_idle_a: assert property (!rd_acc |-> prdata == '0) else $error("prdata not zero");
	ctrl_resv_a: assert property (rd_acc && paddr == WDCFG_OFF_CTRL |-> prdata[31:5] == '0)
		else $error("control reserved bits set");
	cause_resv_a: assert property (rd_acc && paddr == WDCFG_OFF_CAUSE |-> prdata[31:4] == '0)
		else $error("cause reserved bits set");
	fuse_run_a: assert property (always_on_fuse [*6] |-> wd_running)
		else $error("fuse set but not running");
	fuse_read_a: assert property (always_on_fuse [*6] ##0 (rd_acc && paddr == WDCFG_OFF_CTRL)
		|-> prdata[WDCFG_CTRL_EN_BIT]) else $error("enable reads zero");
	rst_pulse_a: assert property (wd_reset |=> !wd_reset) else $error("reset pulse too long");
	rst_cause_a: assert property (wd_reset |-> $past(wd_running))
		else $error("reset while stopped");
	kick_hold_a: assert property (watchdog_kick |=> !wd_reset [*8])
		else $error("reset right after kick");
endmodule
`default_nettype wire

// ===== tb/wdcfg_top_test.sv
// Self-checking bench for the watchdog block
`timescale 1ns/1ns
`default_nettype none
module wdcfg_top_test;
	import wdcfg_pkg::*;
	localparam int unsigned BASE = 4;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        wd_osc, pin_reset_n, brownout_det, always_on_fuse, watchdog_kick;
	logic        wd_reset, wd_running, irq;
	int          failures, tests_run, cyc, n;

	wdcfg_top #(.TIMEOUT_BASE_CYC(BASE)) uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .wd_osc(wd_osc), .pin_reset_n(pin_reset_n),
		.brownout_det(brownout_det), .always_on_fuse(always_on_fuse),
		.watchdog_kick(watchdog_kick), .wd_reset(wd_reset), .wd_running(wd_running), .irq(irq));

	initial begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	// Fast oscillator keeps runs short; only the tick count matters
	initial begin
		wd_osc = 0;
		forever #20 wd_osc = ~wd_osc;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Leaves the bus selected so a back-to-back setup can follow
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
	endtask
	task automatic idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		idle();
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		idle();
		check(rdat, exp);
	endtask
	task automatic done(input int t);
		$display("test %0d done", t);
	endtask
	task automatic expire(input int s);
		int t;
		t = 0;
		xfer(1'b1, WDCFG_OFF_CTRL, 32'h18);
		wr(WDCFG_OFF_CTRL, 32'(8 + s));
		watchdog_kick <= 1'b1;
		@(posedge pclk);
		watchdog_kick <= 1'b0;
		while (wd_reset !== 1'b1 && t < 6000) begin
			@(posedge pclk);
			t++;
		end
		check(32'(t > (BASE << s) * 10 - 12 && t < (BASE << s) * 10 + 20), 32'h1);
		rd(WDCFG_OFF_CAUSE, 32'h8);
		rd(WDCFG_OFF_CTRL, 32'h0);
		rd(WDCFG_OFF_IRQ_STAT, 32'h1);
		wr(WDCFG_OFF_IRQ_STAT, 32'h1);
		wr(WDCFG_OFF_CAUSE, 32'h0);
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{brownout_det, always_on_fuse, watchdog_kick} = '0;
		pin_reset_n = 1;
		{failures, tests_run, cyc} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rd(WDCFG_OFF_CTRL, 32'h0);
		rd(WDCFG_OFF_CAUSE, 32'h1);
		wr(WDCFG_OFF_CAUSE, 32'h0);
		rd(WDCFG_OFF_CAUSE, 32'h0);
		rd(WDCFG_OFF_IRQ_MASK, 32'h0);
		check(32'(wd_running), 32'h0);
		xfer(1'b0, 12'h010, 32'h0);
		idle();
		check(32'(rerr), 32'h1);
		done(1);
		wr(WDCFG_OFF_CTRL, 32'h8);
		// Kick held so the short test timeout cannot fire here
		watchdog_kick <= 1'b1;
		rd(WDCFG_OFF_CTRL, 32'h8);
		wr(WDCFG_OFF_CTRL, 32'h0);
		rd(WDCFG_OFF_CTRL, 32'h8);
		wr(WDCFG_OFF_CTRL, 32'h0d);
		rd(WDCFG_OFF_CTRL, 32'h8);
		rd(WDCFG_OFF_IRQ_STAT, 32'h2);
		wr(WDCFG_OFF_IRQ_MASK, 32'h3);
		@(posedge pclk);
		check(32'(irq), 32'h1);
		wr(WDCFG_OFF_IRQ_STAT, 32'h2);
		@(posedge pclk);
		check(32'(irq), 32'h0);
		done(2);
		xfer(1'b1, WDCFG_OFF_CTRL, 32'h18);
		wr(WDCFG_OFF_CTRL, 32'h2);
		idle();
		rd(WDCFG_OFF_CTRL, 32'h2);
		check(32'(wd_running), 32'h0);
		watchdog_kick <= 1'b0;
		// Read at the second and write at the fourth clock of the window
		xfer(1'b1, WDCFG_OFF_CTRL, 32'h18);
		xfer(1'b0, WDCFG_OFF_CTRL, 32'h0);
		check(rdat, 32'h1a);
		wr(WDCFG_OFF_CTRL, 32'h0);
		rd(WDCFG_OFF_CTRL, 32'h0);
		wr(WDCFG_OFF_CTRL, 32'h18);
		idle();
		idle();
		wr(WDCFG_OFF_CTRL, 32'h0);
		rd(WDCFG_OFF_CTRL, 32'h8);
		wr(WDCFG_OFF_IRQ_STAT, 32'h3);
		done(3);
		for (n = 0; n < 8; n++)
			expire(n);
		done(4);
		pin_reset_n <= 1'b0;
		repeat (4) @(posedge pclk);
		pin_reset_n <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(WDCFG_OFF_CAUSE, 32'h2);
		brownout_det <= 1'b1;
		repeat (4) @(posedge pclk);
		brownout_det <= 1'b0;
		repeat (6) @(posedge pclk);
		rd(WDCFG_OFF_CAUSE, 32'h6);
		wr(WDCFG_OFF_CAUSE, 32'hff);
		rd(WDCFG_OFF_CAUSE, 32'h6);
		wr(WDCFG_OFF_CAUSE, 32'h0);
		rd(WDCFG_OFF_CAUSE, 32'h0);
		done(5);
		always_on_fuse <= 1'b1;
		repeat (6) @(posedge pclk);
		check(32'(wd_running), 32'h1);
		wr(WDCFG_OFF_CTRL, 32'h0);
		rd(WDCFG_OFF_CTRL, 32'h8);
		watchdog_kick <= 1'b1;
		@(posedge pclk);
		watchdog_kick <= 1'b0;
		xfer(1'b1, WDCFG_OFF_CTRL, 32'h18);
		wr(WDCFG_OFF_CTRL, 32'h3);
		idle();
		rd(WDCFG_OFF_CTRL, 32'h0b);
		done(6);
		report_and_stop();
	end
endmodule

bind wdcfg_top wdcfg_monitor #(.TIMEOUT_BASE_CYC(TIMEOUT_BASE_CYC)) mon (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .always_on_fuse(always_on_fuse),
	.watchdog_kick(watchdog_kick), .wd_reset(wd_reset), .wd_running(wd_running));
`default_nettype wire
